/* File: rtl/mss_pkg.sv */
/*
  constants shared by both ends of the management-mode state-save
  slot link, and the slot offset function used by the processor end.
  assumes a 32-bit save area, 32k-aligned base.
*/
// Operation
// [RQ1] revision word: reloc bit17, trap bit16, level
// [RQ2] resume reads revision word back first
// [RQ3] feature bits fixed at one, saved
// [RQ4] auto-halt bit0 set when halt interrupted
// [RQ5] resume: bit0 one re-halts, else continue
// [RQ6] handler never sets auto-halt from zero
// [RQ7] restart halt: fetch if uncached, halt cycle
// [RQ8] io slot 0ffh re-executes, 00h does not
// [RQ9] io restart slot cleared on entry
// [RQ10] io slot written only after io trap
// [RQ11] trap word: addr, valid bit, direction
// [RQ12] valid flag set for genuine io instruction
// [RQ13] direction one for read, zero write
// [RQ14] addr and direction invalid without trap
// [RQ15] chipset raises irq on first rep access
// [RQ16] base resets to 30000h
// [RQ17] save at base, store base, jump base+8000h
// [RQ18] resume latches base slot for next entry
// [RQ19] unaligned base slot on resume shuts down
// [RQ20] relocation honoured only with bit17 set
// [RQ21] handler leaves reserved revision bits alone
// [RQ22] decoder provides 38000h-3ffffh region
// [RQ23] drain stores, assert ack, then save
// [RQ24] revision word saved on every entry
package mss_pkg;
  localparam int          DW            = 32;
  localparam int          OFS_W         = 16;
  localparam logic [15:0] OFS_BASE      = 16'h7ef8;
  localparam logic [15:0] OFS_REVISION  = 16'h7efc;
  localparam logic [15:0] OFS_IO_RESTART = 16'h7f00;
  localparam logic [15:0] OFS_AUTO_HALT = 16'h7f02;
  localparam logic [15:0] OFS_TRAP      = 16'h7fa4;
  localparam logic [31:0] AREA_OFS      = 32'h0000_8000;
  localparam logic [31:0] BASE_RESET    = 32'h0003_0000;
  localparam logic [31:0] ALIGN_MASK    = 32'h0000_7fff;
  localparam logic [31:0] DEF_RAM_LO    = 32'h0003_8000;
  localparam logic [31:0] DEF_RAM_HI    = 32'h0003_ffff;
  localparam int          REV_RELOC_BIT = 17;
  localparam int          REV_TRAP_BIT  = 16;
  localparam int          AH_BIT        = 0;
  localparam int          TRAP_VAL_BIT  = 1;
  localparam int          TRAP_DIR_BIT  = 0;
  localparam int          TRAP_ADDR_LSB = 16;
  localparam logic [31:0] IO_RESTART_YES = 32'h0000_00ff;
  localparam logic [31:0] IO_RESTART_NO  = 32'h0000_0000;
  // slot walk: indices 0..3 restored, 0..4 saved
  localparam logic [2:0]  IDX_REV       = 3'h0;
  localparam logic [2:0]  IDX_AH        = 3'h1;
  localparam logic [2:0]  IDX_IO        = 3'h2;
  localparam logic [2:0]  IDX_BASE      = 3'h3;
  localparam logic [2:0]  IDX_TRAP      = 3'h4;
  localparam logic [2:0]  IDX_LAST_RD   = 3'h3;
  localparam logic [2:0]  IDX_LAST_WR   = 3'h4;
  localparam logic [14:0] SLOT_LOW_MASK = 15'h7fff;
  // controller registers on apb
  localparam logic [7:0]  A_CTRL        = 8'h00;
  localparam logic [7:0]  A_STATUS      = 8'h04;
  localparam logic [7:0]  A_BASE        = 8'h08;
  localparam logic [7:0]  A_IO          = 8'h0c;
  localparam logic [7:0]  A_AH          = 8'h10;
  localparam logic [7:0]  A_REV         = 8'h14;
  localparam logic [7:0]  A_TRAP        = 8'h18;
  localparam int          CTRL_IRQ_BIT  = 0;
  localparam int          CTRL_RSM_BIT  = 1;

  // slot offset within the save area for a walk index
  function automatic logic [15:0] slot_ofs(
    input logic [2:0] idx);
    case (idx)
      IDX_REV:  slot_ofs = OFS_REVISION;
      IDX_AH:   slot_ofs = OFS_AUTO_HALT;
      IDX_IO:   slot_ofs = OFS_IO_RESTART;
      IDX_BASE: slot_ofs = OFS_BASE;
      default:  slot_ofs = OFS_TRAP;
    endcase
  endfunction
endpackage

/* File: rtl/mss_link_if.sv */
/*
  link between the processor slot logic and the
  chipset: irq, ack, resume and the slot bus.
  assumes both ends share one clock.
*/
`timescale 1ns/100ps
interface mss_link_if;
  logic        sys_mgmt_irq;
  logic        mgmt_active_ack;
  logic        resume_from_mgmt_mode;
  logic        slot_wr;
  logic        slot_rd;
  logic [31:0] slot_addr;
  logic [31:0] slot_wdata;
  logic        slot_rvalid;
  logic [31:0] slot_rdata;

  modport dev (
    input  sys_mgmt_irq, resume_from_mgmt_mode,
    input  slot_rvalid, slot_rdata,
    output mgmt_active_ack, slot_wr, slot_rd,
    output slot_addr, slot_wdata
  );
  modport chip (
    output sys_mgmt_irq, resume_from_mgmt_mode,
    output slot_rvalid, slot_rdata,
    input  mgmt_active_ack, slot_wr, slot_rd,
    input  slot_addr, slot_wdata
  );
endinterface // mss_link_if

/* File: rtl/mss_dev.sv */
/*
  processor end: enters management mode, writes
  the state-save slots, reads all but the trap slot back on resume.
  assumes the chipset answers a slot read with
  slot_rvalid some cycles later.
*/
// Added by the designer: register access over APB.
`timescale 1ns/100ps
module mss_dev #(
  parameter logic [15:0] REV_LEVEL  = 16'h0011, // arbitrary
  parameter bit          FEAT_RELOC = 1'b1,
  parameter bit          FEAT_TRAP  = 1'b1
) (
  input  wire logic        clock,
  input  wire logic        arst_n,
  mss_link_if.dev          lnk,
  input  wire logic        stores_pending,
  input  wire logic        core_halted,
  input  wire logic        halt_cached,
  input  wire logic [15:0] io_trap_addr,
  input  wire logic        io_trap_valid,
  input  wire logic        io_trap_read,
  output logic             in_mgmt_mode,
  output logic             entry_pulse,
  output logic [31:0]      entry_vector,
  output logic [31:0]      cur_base,
  output logic             halt_fetch,
  output logic             halt_cycle,
  output logic             continue_next,
  output logic             io_reexec,
  output logic             shutdown
);
  import mss_pkg::*;

  typedef enum logic [8:0] {
    S_IDLE  = 9'h001,
    S_DRAIN = 9'h002,
    S_SAVE  = 9'h004,
    S_RUN   = 9'h008,
    S_RD    = 9'h010,
    S_WAIT  = 9'h020,
    S_APPLY = 9'h040,
    S_FETCH = 9'h080,
    S_SHUT  = 9'h100
  } mss_state_type;

  mss_state_type state_r;
  mss_state_type state_nxt;
  logic [2:0]    idx_r;
  logic [31:0]   base_r;
  logic          halt_r;
  logic [31:0]   trap_r;
  logic [31:0]   ah_rd_r;
  logic [31:0]   io_rd_r;
  logic [31:0]   base_rd_r;
  logic [31:0]   rev_rd_r;
  logic          ack_r;
  logic          wr_r;
  logic          rd_r;
  logic [31:0]   addr_r;
  logic [31:0]   wdata_r;
  logic          entry_r;
  logic          fetch_r;
  logic          hcyc_r;
  logic          cont_r;
  logic          iox_r;

  // fixed revision word, reserved bits zero
  wire [31:0] rev_word = {14'h0000, FEAT_RELOC, FEAT_TRAP,
                          REV_LEVEL}; // [RQ1] [RQ3]
  wire [31:0] trap_word = {io_trap_addr, 14'h0000,
                           io_trap_valid,
                           io_trap_read}; // [RQ11] [RQ12] [RQ13]
  // save data per walk index
  wire [31:0] save_data =
    (idx_r == IDX_REV)  ? rev_word :       // [RQ24] [RQ3]
    (idx_r == IDX_AH)   ? {31'h0, halt_r} : // [RQ4]
    (idx_r == IDX_IO)   ? IO_RESTART_NO :  // [RQ9]
    (idx_r == IDX_BASE) ? base_r :         // [RQ17]
                          trap_r;
  // save area follows the current base
  wire [31:0] slot_at = base_r + AREA_OFS
                        + {16'h0000, slot_ofs(idx_r)}; // [RQ17]
  wire        save_done = (idx_r == IDX_LAST_WR);
  wire        rd_done   = (idx_r == IDX_LAST_RD);
  // relocation checks on the value read back
  wire        reloc_on  = FEAT_RELOC;        // [RQ20]
  wire        misalign  = reloc_on &&
                          ((base_rd_r & ALIGN_MASK) != 32'h0);
  wire        rehalt    = ah_rd_r[AH_BIT];  // [RQ5]
  wire        do_iox    = (io_rd_r == IO_RESTART_YES); // [RQ8]

  // sequencing of entry, save, resume and restore
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      S_IDLE:  if (lnk.sys_mgmt_irq) state_nxt = S_DRAIN;
      // stores drain before ack goes out [RQ23]
      S_DRAIN: if (!stores_pending) state_nxt = S_SAVE;
      S_SAVE:  if (save_done) state_nxt = S_RUN;
      S_RUN:   if (lnk.resume_from_mgmt_mode) state_nxt = S_RD;
      S_RD:    state_nxt = S_WAIT;
      S_WAIT:  if (lnk.slot_rvalid)
                 state_nxt = rd_done ? S_APPLY : S_RD;
      S_APPLY: if (misalign) state_nxt = S_SHUT; // [RQ19]
               else if (rehalt && !halt_cached)
                 state_nxt = S_FETCH;            // [RQ7]
               else state_nxt = S_IDLE;
      S_FETCH: state_nxt = S_IDLE;
      S_SHUT:  state_nxt = S_SHUT; // left only by reset
      default: state_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) state_r <= S_IDLE;
    else state_r <= state_nxt;
  end

  // walk index: save 0..4, restore 0..3
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) idx_r <= IDX_REV;
    else if (state_r == S_DRAIN || state_r == S_RUN)
      idx_r <= IDX_REV;
    else if (state_r == S_SAVE && !save_done)
      idx_r <= idx_r + 3'h1;
    else if (state_r == S_WAIT && lnk.slot_rvalid && !rd_done)
      idx_r <= idx_r + 3'h1;
  end

  // halt and trap context caught at recognition
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      halt_r <= 1'b0;
      trap_r <= 32'h0;
    end else if (state_r == S_IDLE && lnk.sys_mgmt_irq) begin
      halt_r <= core_halted;   // [RQ4]
      trap_r <= trap_word;     // [RQ14]
    end
  end

  // restored slot values, captured by index
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rev_rd_r  <= 32'h0;
      ah_rd_r   <= 32'h0;
      io_rd_r   <= 32'h0;
      base_rd_r <= BASE_RESET;
    end else if (state_r == S_WAIT && lnk.slot_rvalid) begin
      if (idx_r == IDX_REV)  rev_rd_r  <= lnk.slot_rdata; // [RQ2]
      if (idx_r == IDX_AH)   ah_rd_r   <= lnk.slot_rdata;
      if (idx_r == IDX_IO)   io_rd_r   <= lnk.slot_rdata;
      if (idx_r == IDX_BASE) base_rd_r <= lnk.slot_rdata;
    end
  end

  // base register: reset default, relatched on resume
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) base_r <= BASE_RESET;            // [RQ16]
    else if (state_r == S_APPLY && reloc_on && !misalign)
      base_r <= base_rd_r;                        // [RQ18] [RQ20]
  end

  // ack rises after the drain, falls once restored
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) ack_r <= 1'b0;
    else if (state_r == S_DRAIN && !stores_pending)
      ack_r <= 1'b1;                              // [RQ23]
    else if (state_r == S_APPLY)
      ack_r <= 1'b0;
  end

  // slot bus drive; a write follows ack by one cycle
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wr_r    <= 1'b0;
      rd_r    <= 1'b0;
      addr_r  <= 32'h0;
      wdata_r <= 32'h0;
    end else begin
      wr_r <= (state_r == S_SAVE);
      rd_r <= (state_r == S_RD);                  // [RQ2]
      if (state_r == S_SAVE || state_r == S_RD) begin
        addr_r  <= slot_at;
        wdata_r <= save_data;
      end
    end
  end

  // one-cycle pulses toward the core
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      entry_r <= 1'b0;
      fetch_r <= 1'b0;
      hcyc_r  <= 1'b0;
      cont_r  <= 1'b0;
      iox_r   <= 1'b0;
    end else begin
      entry_r <= (state_r == S_SAVE) && save_done;  // [RQ17]
      fetch_r <= (state_r == S_APPLY) && !misalign
                 && rehalt && !halt_cached;         // [RQ7]
      hcyc_r  <= ((state_r == S_APPLY) && !misalign
                  && rehalt && halt_cached)
                 || (state_r == S_FETCH);           // [RQ5] [RQ7]
      cont_r  <= (state_r == S_APPLY) && !misalign
                 && !rehalt;                        // [RQ5]
      iox_r   <= (state_r == S_APPLY) && !misalign
                 && do_iox;                         // [RQ8]
    end
  end

  // handler start address, computed at save end
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) entry_vector <= BASE_RESET + AREA_OFS;
    else if (state_r == S_SAVE && save_done)
      entry_vector <= base_r + AREA_OFS;          // [RQ17]
  end

  // mode and shutdown levels
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      in_mgmt_mode <= 1'b0;
      shutdown     <= 1'b0;
      cur_base     <= BASE_RESET;
    end else begin
      in_mgmt_mode <= ack_r;
      shutdown     <= (state_nxt == S_SHUT);      // [RQ19]
      cur_base     <= base_r;
    end
  end

  assign lnk.mgmt_active_ack = ack_r;
  assign lnk.slot_wr         = wr_r;
  assign lnk.slot_rd         = rd_r;
  assign lnk.slot_addr       = addr_r;
  assign lnk.slot_wdata      = wdata_r;
  assign entry_pulse         = entry_r;
  assign halt_fetch          = fetch_r;
  assign halt_cycle          = hcyc_r;
  assign continue_next       = cont_r;
  assign io_reexec           = iox_r;
endmodule // mss_dev

/* File: rtl/mss_chip.sv */
/*
  chipset end: raises the irq, stores the save
  slots, and lets software reach them over apb.
  assumes an apb master with one wait state seen.
*/
`timescale 1ns/100ps
module mss_chip (
  input  wire logic        clock,
  input  wire logic        arst_n,
  mss_link_if.chip         lnk,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        io_trap_req,
  input  wire logic [31:0] mem_addr,
  output logic             mgmt_ram_hit
);
  import mss_pkg::*;

  logic [31:0] base_s_r;
  logic [31:0] io_s_r;
  logic [31:0] ah_s_r;
  logic [31:0] rev_s_r;
  logic [31:0] trap_s_r;
  logic        ah_entry_r;
  logic        irq_r;
  logic        rsm_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;

  // slot decode: base is 32k aligned, low bits pick slot
  wire [15:0] sofs = {1'b0, lnk.slot_addr[14:0] & SLOT_LOW_MASK};
  wire dw = lnk.slot_wr;
  // apb decode, write lands at the ready edge
  wire acc  = psel && penable && pready;
  wire wen  = acc && pwrite;
  wire hit  = (paddr == A_CTRL) || (paddr == A_STATUS) ||
              (paddr == A_BASE) || (paddr == A_IO) ||
              (paddr == A_AH) || (paddr == A_REV) ||
              (paddr == A_TRAP);
  wire [31:0] status = {29'h0, trap_s_r[TRAP_VAL_BIT], irq_r,
                        lnk.mgmt_active_ack};
  wire [31:0] rmux =
    (paddr == A_STATUS) ? status :
    (paddr == A_BASE)   ? base_s_r :
    (paddr == A_IO)     ? io_s_r :
    (paddr == A_AH)     ? ah_s_r :
    (paddr == A_REV)    ? rev_s_r :
    (paddr == A_TRAP)   ? trap_s_r : 32'h0;
  wire [31:0] smux =
    (sofs == OFS_REVISION)   ? rev_s_r :
    (sofs == OFS_AUTO_HALT)  ? ah_s_r :
    (sofs == OFS_IO_RESTART) ? io_s_r :
    (sofs == OFS_BASE)       ? base_s_r : trap_s_r;
  // a zero entry value keeps the halt bit at zero
  wire [31:0] ah_w = {pwdata[31:1],
                      pwdata[AH_BIT] & ah_entry_r}; // [RQ6]
  // io restart only accepted after a genuine io trap
  wire io_ok = trap_s_r[TRAP_VAL_BIT];              // [RQ10]

  // apb answer: one wait state, error off the map
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !hit;
      if (psel && penable && !pready) prdata <= rmux;
    end
  end

  // slot storage: device saves win over software
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      base_s_r   <= BASE_RESET;
      io_s_r     <= IO_RESTART_NO;
      ah_s_r     <= 32'h0;
      rev_s_r    <= 32'h0;
      trap_s_r   <= 32'h0;
      ah_entry_r <= 1'b0;
    end else if (dw) begin
      if (sofs == OFS_BASE)       base_s_r <= lnk.slot_wdata;
      if (sofs == OFS_IO_RESTART) io_s_r   <= lnk.slot_wdata;
      if (sofs == OFS_REVISION)   rev_s_r  <= lnk.slot_wdata;
      if (sofs == OFS_TRAP)       trap_s_r <= lnk.slot_wdata;
      if (sofs == OFS_AUTO_HALT) begin
        ah_s_r     <= lnk.slot_wdata;
        ah_entry_r <= lnk.slot_wdata[AH_BIT];
      end
    end else if (wen) begin
      // revision and trap words stay read-only [RQ21]
      if (paddr == A_BASE) base_s_r <= pwdata;
      if (paddr == A_IO && io_ok) io_s_r <= pwdata; // [RQ10]
      if (paddr == A_AH) ah_s_r <= ah_w;             // [RQ6]
    end
  end

  // irq held until ack; a new request beats the clear
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) irq_r <= 1'b0;
    else if (io_trap_req ||
             (wen && paddr == A_CTRL && pwdata[CTRL_IRQ_BIT]))
      irq_r <= 1'b1;                                // [RQ15]
    else if (lnk.mgmt_active_ack)
      irq_r <= 1'b0;
  end

  // resume pulse only while the device is in the mode
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) rsm_r <= 1'b0;
    else rsm_r <= wen && paddr == A_CTRL &&
                  pwdata[CTRL_RSM_BIT] && lnk.mgmt_active_ack;
  end

  // slot read answer one cycle after the request
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0;
    end else begin
      rvalid_r <= lnk.slot_rd;
      if (lnk.slot_rd) rdata_r <= smux;
    end
  end

  // default management region decode
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) mgmt_ram_hit <= 1'b0;
    else mgmt_ram_hit <= (mem_addr >= DEF_RAM_LO) &&
                         (mem_addr <= DEF_RAM_HI); // [RQ22]
  end

  assign lnk.sys_mgmt_irq          = irq_r;
  assign lnk.resume_from_mgmt_mode = rsm_r;
  assign lnk.slot_rvalid           = rvalid_r;
  assign lnk.slot_rdata            = rdata_r;
endmodule // mss_chip

/* File: bench/mss_link_assertions.sv */
/*
  checker for the slot link between the two ends.
  assumes it is instantiated beside the link and
  fed its signals, clock and reset by name.
*/
`timescale 1ns/100ps
module mss_link_assertions #(
  parameter logic [15:0] REV_LEVEL = 16'h0011 // arbitrary
) (
  input wire logic        clock,
  input wire logic        arst_n,
  input wire logic        sys_mgmt_irq,
  input wire logic        mgmt_active_ack,
  input wire logic        resume_from_mgmt_mode,
  input wire logic        slot_wr,
  input wire logic        slot_rd,
  input wire logic [31:0] slot_addr,
  input wire logic [31:0] slot_wdata,
  input wire logic        slot_rvalid,
  input wire logic [31:0] slot_rdata
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  // slot low offsets seen on the wire
  wire logic [14:0] lo = slot_addr[14:0];

  property p_irq_ack;
    $rose(sys_mgmt_irq) |-> ##[1:40] mgmt_active_ack;
  endproperty
  a_irq_ack: assert property (p_irq_ack)
    else $error("ack missing after irq");
  // fixed save order, io slot cleared on the way
  property p_save_order;
    $rose(mgmt_active_ack) |-> ##1 (slot_wr && lo == 15'h7efc)
      ##1 (slot_wr && lo == 15'h7f02)
      ##1 (slot_wr && lo == 15'h7f00 && slot_wdata == 32'h0)
      ##1 (slot_wr && lo == 15'h7ef8) ##1 (slot_wr && lo == 15'h7fa4);
  endproperty
  a_save_order: assert property (p_save_order)
    else $error("save walk out of order");
  property p_rev_word;
    slot_wr && lo == 15'h7efc |->
      slot_wdata == {14'h0, 1'b1, 1'b1, REV_LEVEL};
  endproperty
  a_rev_word: assert property (p_rev_word)
    else $error("revision word wrong");
  property p_base_slot;
    slot_wr && lo == 15'h7ef8 |->
      slot_addr == slot_wdata + 32'h0000_8000 + 32'h0000_7ef8;
  endproperty
  a_base_slot: assert property (p_base_slot)
    else $error("base slot not current base");
  property p_trap_rsvd;
    slot_wr && lo == 15'h7fa4 |-> slot_wdata[15:2] == 14'h0;
  endproperty
  a_trap_rsvd: assert property (p_trap_rsvd)
    else $error("trap word reserved bits set");
  property p_rd_answer;
    slot_rd |=> slot_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("slot read not answered");
  property p_resume_rev;
    resume_from_mgmt_mode && mgmt_active_ack |->
      ##[1:4] (slot_rd && lo == 15'h7efc);
  endproperty
  a_resume_rev: assert property (p_resume_rev)
    else $error("resume skipped revision read");
  property p_in_mode;
    slot_wr || slot_rd |-> mgmt_active_ack;
  endproperty
  a_in_mode: assert property (p_in_mode)
    else $error("slot access outside mode");
  property p_ack_hold;
    $rose(mgmt_active_ack) |-> mgmt_active_ack [*8];
  endproperty
  a_ack_hold: assert property (p_ack_hold)
    else $error("ack dropped during save");
  c_entry: cover property ($rose(mgmt_active_ack));
  c_resume: cover property (resume_from_mgmt_mode);
  c_read: cover property (slot_rd ##1 slot_rvalid);
endmodule // mss_link_assertions

/* File: bench/mgmt_mode_state_save_slots_test.sv */
/*
  self-checking bench: both ends joined by the link,
  software side driven over apb.
  assumes the one-wait-state apb answer of the chip.
*/
`timescale 1ns/100ps
module mgmt_mode_state_save_slots_test;
  import mss_pkg::*;
  localparam logic [15:0] REV_LVL = 16'h0011; // arbitrary
  logic clock = 0, arst_n = 0, stores_pending = 0, core_halted = 0;
  logic halt_cached = 0, io_trap_valid = 0, io_trap_read = 0;
  logic [15:0] io_trap_addr = 16'h0;
  logic [7:0]  paddr = 8'h0;
  logic        psel = 0, penable = 0, pwrite = 0, io_trap_req = 0;
  logic [31:0] pwdata = 32'h0, mem_addr = 32'h0, q, prdata;
  logic        e, pready, pslverr, mgmt_ram_hit, in_mgmt_mode;
  logic        entry_pulse, halt_fetch, halt_cycle, continue_next;
  logic        io_reexec, shutdown;
  logic [31:0] entry_vector, cur_base;
  logic [4:0]  seen = 5'h0;
  logic        seen_clr = 0;
  int          error_cnt = 0, total_checks = 0;

  always #25 clock = ~clock;
  mss_link_if mss_link_if_inst ();
  mss_dev #(.REV_LEVEL(REV_LVL)) mss_dev_inst (
    .clock(clock), .arst_n(arst_n), .lnk(mss_link_if_inst),
    .stores_pending(stores_pending), .core_halted(core_halted),
    .halt_cached(halt_cached), .io_trap_addr(io_trap_addr),
    .io_trap_valid(io_trap_valid), .io_trap_read(io_trap_read),
    .in_mgmt_mode(in_mgmt_mode), .entry_pulse(entry_pulse),
    .entry_vector(entry_vector), .cur_base(cur_base),
    .halt_fetch(halt_fetch), .halt_cycle(halt_cycle),
    .continue_next(continue_next), .io_reexec(io_reexec),
    .shutdown(shutdown));
  mss_chip mss_chip_inst (
    .clock(clock), .arst_n(arst_n), .lnk(mss_link_if_inst),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .io_trap_req(io_trap_req),
    .mem_addr(mem_addr), .mgmt_ram_hit(mgmt_ram_hit));
  mss_link_assertions #(.REV_LEVEL(REV_LVL)) mss_link_assertions_inst (
    .clock(clock), .arst_n(arst_n),
    .sys_mgmt_irq(mss_link_if_inst.sys_mgmt_irq),
    .mgmt_active_ack(mss_link_if_inst.mgmt_active_ack),
    .resume_from_mgmt_mode(mss_link_if_inst.resume_from_mgmt_mode),
    .slot_wr(mss_link_if_inst.slot_wr),
    .slot_rd(mss_link_if_inst.slot_rd),
    .slot_addr(mss_link_if_inst.slot_addr),
    .slot_wdata(mss_link_if_inst.slot_wdata),
    .slot_rvalid(mss_link_if_inst.slot_rvalid),
    .slot_rdata(mss_link_if_inst.slot_rdata));

  // sticky record of resume outcome pulses
  always @(posedge clock) begin
    if (seen_clr) seen <= 5'h0;
    else seen <= seen | {shutdown, io_reexec, continue_next,
                         halt_cycle, halt_fetch};
  end

  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, x);
    total_checks++;
    if (s !== x) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, x, s);
    end
  endtask

  // one apb transfer; pready sampled at the rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      error_cnt++;
      end_sim();
    end
    // request held up to this edge; answer taken here
    q = prdata;
    e = pslverr;
    psel <= 0; penable <= 0;
  endtask

  // enter the mode and read every saved slot back
  task automatic do_entry(input logic h, c, t, r, input logic [15:0] ta,
                          input logic [31:0] base);
    int n;
    @(posedge clock);
    core_halted <= h; halt_cached <= c; io_trap_valid <= t;
    io_trap_read <= r; io_trap_addr <= ta; stores_pending <= 1;
    @(posedge clock);
    if (t) begin
      io_trap_req <= 1;
      @(posedge clock);
      io_trap_req <= 0;
    end else apb(1, A_CTRL, 32'h1);
    repeat (3) @(negedge clock);
    chk("ack early", {31'h0, mss_link_if_inst.mgmt_active_ack}, 0);
    @(posedge clock);
    stores_pending <= 0;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (entry_pulse !== 1'b1 && n < 50);
    if (entry_pulse !== 1'b1) begin
      error_cnt++;
      end_sim();
    end
    chk("vector", entry_vector, base + 32'h8000);
    chk("mode", {31'h0, in_mgmt_mode}, 1);
    apb(0, A_REV, 0);
    chk("rev", q, {14'h0, 1'b1, 1'b1, REV_LVL});
    apb(0, A_AH, 0);
    chk("auto halt", q, {31'h0, h});
    apb(0, A_IO, 0);
    chk("io slot", q, 0);
    apb(0, A_BASE, 0);
    chk("base slot", q, base);
    apb(0, A_TRAP, 0);
    if (t) chk("trap", q, {ta, 14'h0, 1'b1, r});
    else chk("trap valid", q & 32'h2, 0);
  endtask

  task automatic do_resume(input logic [4:0] x, m);
    int n;
    seen_clr <= 1;
    @(posedge clock);
    seen_clr <= 0;
    apb(1, A_CTRL, 32'h2);
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (mss_link_if_inst.mgmt_active_ack !== 1'b0 && n < 40);
    if (mss_link_if_inst.mgmt_active_ack !== 1'b0) begin
      error_cnt++;
      end_sim();
    end
    repeat (3) @(negedge clock);
    chk("outcome", {27'h0, seen & m}, {27'h0, x & m});
  endtask

  task automatic t_reset();
    chk("cur base", cur_base, BASE_RESET);
    apb(0, A_BASE, 0);
    chk("base reset", q, BASE_RESET);
    apb(0, 8'h20, 0);
    chk("unmapped err", {31'h0, e}, 1);
    mem_addr <= DEF_RAM_LO;
    repeat (2) @(negedge clock);
    chk("ram lo", {31'h0, mgmt_ram_hit}, 1);
    @(posedge clock);
    mem_addr <= DEF_RAM_LO - 32'h1;
    repeat (2) @(negedge clock);
    chk("ram below", {31'h0, mgmt_ram_hit}, 0);
  endtask

  // halt interrupted on a read trap, handler relocates and restarts io
  task automatic t_halt_reloc();
    do_entry(1, 0, 1, 1, 16'h03f8, BASE_RESET);
    apb(1, A_IO, IO_RESTART_YES);
    apb(1, A_BASE, 32'h0004_0000);
    do_resume(5'b01011, 5'b11111);
    chk("relocated", cur_base, 32'h0004_0000);
  endtask

  // handler tries writes the chip must refuse
  task automatic t_guards();
    do_entry(0, 0, 0, 0, 16'h0, 32'h0004_0000);
    apb(1, A_AH, 32'h1);
    apb(1, A_IO, IO_RESTART_YES);
    apb(1, A_REV, 32'h0);
    apb(0, A_AH, 0);
    chk("ah guard", q, 0);
    apb(0, A_IO, 0);
    chk("io guard", q, 0);
    apb(0, A_REV, 0);
    chk("rev ro", q, {14'h0, 1'b1, 1'b1, REV_LVL});
    do_resume(5'b00100, 5'b11111);
  endtask

  // cached halt on a write trap, slots left as saved
  task automatic t_cached();
    do_entry(1, 1, 1, 0, 16'h0060, 32'h0004_0000);
    do_resume(5'b00010, 5'b11111);
  endtask

  task automatic t_shutdown();
    do_entry(0, 0, 0, 0, 16'h0, 32'h0004_0000);
    apb(1, A_BASE, 32'h0004_1000);
    do_resume(5'b10000, 5'b10000);
    repeat (5) @(negedge clock);
    chk("shutdown", {31'h0, shutdown}, 1);
  endtask

  // hang guard
  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    end_sim();
  end

  initial begin
    repeat (16) @(posedge clock);
    arst_n <= 1;
    t_reset();
    t_halt_reloc();
    t_guards();
    t_cached();
    t_shutdown();
    end_sim();
  end
endmodule // mgmt_mode_state_save_slots_test
